// >>> design/ccr_pkg.sv
// Constants for the converter configuration register slice.
// Assumes a byte-wide register port driven from the device's own clock domain.
// Notes on behaviour
// - A read-only 24-bit word reports where the sync reference edge was captured.
// - A 16-bit full-scale code, shared by all channels, resets to 0xa000.
// - Code 0x2000 means 500 mVPP, 0xa000 800 mVPP, 0xffff 1000 mVPP.
// - Power profile resets to 0x4b high performance; 0x46 low power; others reserved.
// - Timestamp control bit 0 enables the timestamp input; register resets to 0x00.
// - Reference clock output runs only with synthesizer enabled and enable bit set.
// - Reference output enable resets to 1; its register resets to 0x01.
// - Divider register resets 0x00; post divider bits 3:2, first divider bits 1:0.
// - Post divider codes 0,1,2 divide by 1,2,4; code 3 reserved.
// - First divider codes 0,1,2 divide by 5,4,3; code 3 reserved.
package ccr_pkg;
    // =====================================================================
    // Register offsets
    localparam logic [7:0]  OFS_POS_LO   = 8'h2c;
    localparam logic [7:0]  OFS_POS_MID  = 8'h2d;
    localparam logic [7:0]  OFS_POS_HI   = 8'h2e;
    localparam logic [7:0]  OFS_FSR_LO   = 8'h30;
    localparam logic [7:0]  OFS_FSR_HI   = 8'h31;
    localparam logic [7:0]  OFS_PWR      = 8'h37;
    localparam logic [7:0]  OFS_TIMESTAMP_INPUT    = 8'h3b;
    localparam logic [7:0]  OFS_REFO     = 8'h3c;
    localparam logic [7:0]  OFS_DIV1     = 8'h3d;
    // =====================================================================
    // Reset values
    localparam logic [15:0] RST_FSR      = 16'ha000;
    localparam logic [7:0]  RST_PWR      = 8'h4b;
    localparam logic [7:0]  RST_TIMESTAMP_INPUT    = 8'h00;
    localparam logic [7:0]  RST_REFO     = 8'h01;
    localparam logic [7:0]  RST_DIV1     = 8'h00;
    // =====================================================================
    // Field positions and codes
    localparam int          BIT_TIMESTAMP_INPUT_EN = 0;
    localparam int          BIT_REFO_EN  = 0;
    localparam int          POST_LSB     = 2;
    localparam int          FIRST_LSB    = 0;
    localparam logic [7:0]  PWR_LOW      = 8'h46;
    localparam logic [7:0]  PWR_HIGH     = 8'h4b;
    localparam logic [15:0] FSR_MIN_REC  = 16'h2000;
endpackage : ccr_pkg

// >>> design/ccr_regs.sv
// Register slice of the converter configuration map.
// Assumes the serial port front end delivers byte writes and reads on clk.
`timescale 1ns/10ps
module ccr_regs (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    input  wire logic [23:0] sync_edge_position_in,
    input  wire logic        synth_enable,
    output logic      [15:0] full_scale_code,
    output logic             fs_below_min,
    output logic      [7:0]  power_profile_code,
    output logic             power_low_mode,
    output logic             power_reserved,
    output logic             timestamp_input_enable,
    output logic             ref_clock_output,
    output logic      [2:0]  post_div_ratio,
    output logic      [2:0]  first_div_ratio,
    output logic             div_code_reserved
);
    // =====================================================================
    // Storage
    logic [23:0] pos_s1_q;
    logic [23:0] pos_s2_q;
    logic [23:0] pos_s3_q;
    logic [23:0] pos_q;
    logic [23:0] pos_d;
    logic [15:0] fsr_q;
    logic [15:0] fsr_d;
    logic [7:0]  pwr_q;
    logic [7:0]  pwr_d;
    logic [7:0]  timestamp_input_q;
    logic [7:0]  timestamp_input_d;
    logic [7:0]  refo_q;
    logic [7:0]  refo_d;
    logic [7:0]  div_q;
    logic [7:0]  div_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        syn_s1_q;
    logic        syn_q;

    // Status bytes answer reads only; shared by the write path and the checks
    function automatic logic pos_hit(input logic [7:0] a);
        pos_hit = (a == ccr_pkg::OFS_POS_LO) || (a == ccr_pkg::OFS_POS_MID) ||
                  (a == ccr_pkg::OFS_POS_HI);
    endfunction : pos_hit

    function automatic logic [2:0] post_ratio(input logic [1:0] c);
        case (c)
            2'h0: post_ratio = 3'h1;
            2'h1: post_ratio = 3'h2;
            2'h2: post_ratio = 3'h4;
            default: post_ratio = 3'h0;
        endcase
    endfunction : post_ratio

    function automatic logic [2:0] first_ratio(input logic [1:0] c);
        case (c)
            2'h0: first_ratio = 3'h5;
            2'h1: first_ratio = 3'h4;
            2'h2: first_ratio = 3'h3;
            default: first_ratio = 3'h0;
        endcase
    endfunction : first_ratio

    // =====================================================================
    // Next-state logic
    always_comb begin
        fsr_d   = fsr_q;
        pwr_d   = pwr_q;
        timestamp_input_d = timestamp_input_q;
        refo_d  = refo_q;
        div_d   = div_q;
        rdata_d = rdata_q;
        // A torn word never reaches software: bits move only after two equal samples
        pos_d   = (pos_s2_q == pos_s3_q) ? pos_s2_q : pos_q;
        if (wr_en && !pos_hit(addr)) begin
            // Edge-position offsets fall through: no storage is touched
            case (addr)
                ccr_pkg::OFS_FSR_LO: fsr_d[7:0]  = wdata;
                ccr_pkg::OFS_FSR_HI: fsr_d[15:8] = wdata;
                ccr_pkg::OFS_PWR:    pwr_d       = wdata;
                ccr_pkg::OFS_TIMESTAMP_INPUT:  timestamp_input_d     = wdata;
                ccr_pkg::OFS_REFO:   refo_d      = wdata;
                ccr_pkg::OFS_DIV1:   div_d       = wdata;
                default: ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                ccr_pkg::OFS_POS_LO:  rdata_d = pos_q[7:0];
                ccr_pkg::OFS_POS_MID: rdata_d = pos_q[15:8];
                ccr_pkg::OFS_POS_HI:  rdata_d = pos_q[23:16];
                ccr_pkg::OFS_FSR_LO:  rdata_d = fsr_q[7:0];
                ccr_pkg::OFS_FSR_HI:  rdata_d = fsr_q[15:8];
                ccr_pkg::OFS_PWR:     rdata_d = pwr_q;
                ccr_pkg::OFS_TIMESTAMP_INPUT:   rdata_d = timestamp_input_q;
                ccr_pkg::OFS_REFO:    rdata_d = refo_q;
                ccr_pkg::OFS_DIV1:    rdata_d = div_q;
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    // =====================================================================
    // Registers; status word and enable are foreign, so three stages for the word, two for the enable
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fsr_q    <= ccr_pkg::RST_FSR;
            pwr_q    <= ccr_pkg::RST_PWR;
            timestamp_input_q  <= ccr_pkg::RST_TIMESTAMP_INPUT;
            refo_q   <= ccr_pkg::RST_REFO;
            div_q    <= ccr_pkg::RST_DIV1;
            rdata_q  <= 8'h00;
            pos_s1_q <= 24'h000000;
            pos_s2_q <= 24'h000000;
            pos_s3_q <= 24'h000000;
            pos_q    <= 24'h000000;
            syn_s1_q <= 1'b0;
            syn_q    <= 1'b0;
        end else if (clk_en) begin
            fsr_q    <= fsr_d;
            pwr_q    <= pwr_d;
            timestamp_input_q  <= timestamp_input_d;
            refo_q   <= refo_d;
            div_q    <= div_d;
            rdata_q  <= rdata_d;
            pos_s1_q <= sync_edge_position_in;
            pos_s2_q <= pos_s1_q;
            pos_s3_q <= pos_s2_q;
            pos_q    <= pos_d;
            syn_s1_q <= synth_enable;
            syn_q    <= syn_s1_q;
        end
    end

    // =====================================================================
    // Outputs
    assign rdata                  = rdata_q;
    assign full_scale_code        = fsr_q;
    // Flags codes under the recommended floor; hardware still applies them
    assign fs_below_min           = fsr_q < ccr_pkg::FSR_MIN_REC;
    assign power_profile_code     = pwr_q;
    assign power_low_mode         = pwr_q == ccr_pkg::PWR_LOW;
    assign power_reserved         = (pwr_q != ccr_pkg::PWR_LOW) &&
                                    (pwr_q != ccr_pkg::PWR_HIGH);
    assign timestamp_input_enable = timestamp_input_q[ccr_pkg::BIT_TIMESTAMP_INPUT_EN];
    assign ref_clock_output       = syn_q && refo_q[ccr_pkg::BIT_REFO_EN];
    assign post_div_ratio  = post_ratio(div_q[ccr_pkg::POST_LSB +: 2]);
    assign first_div_ratio = first_ratio(div_q[ccr_pkg::FIRST_LSB +: 2]);
    assign div_code_reserved = (post_div_ratio == 3'h0) || (first_div_ratio == 3'h0);

    // =====================================================================
    // Checks
    // Bus events for the checks; the full-scale high byte and power writes serve several
    sequence s_read_quiet;
        clk_en && rd_en && !wr_en;
    endsequence

    sequence s_fsr_lo_write;
        clk_en && wr_en && addr == ccr_pkg::OFS_FSR_LO;
    endsequence

    sequence s_fsr_hi_write;
        clk_en && wr_en && addr == ccr_pkg::OFS_FSR_HI;
    endsequence

    sequence s_pwr_write;
        clk_en && wr_en && addr == ccr_pkg::OFS_PWR;
    endsequence

    sequence s_timestamp_input_write;
        clk_en && wr_en && addr == ccr_pkg::OFS_TIMESTAMP_INPUT;
    endsequence

    sequence s_refo_write;
        clk_en && wr_en && addr == ccr_pkg::OFS_REFO;
    endsequence

    sequence s_div_write;
        clk_en && wr_en && addr == ccr_pkg::OFS_DIV1;
    endsequence

    sequence s_pos_poke;
        clk_en && wr_en && pos_hit(addr) && pos_s2_q == pos_q;
    endsequence

    // Enable input must sit two enabled edges before the gate may follow it
    sequence s_synth_low_held;
        clk_en && !synth_enable ##1 clk_en;
    endsequence

    sequence s_synth_high_held;
        clk_en && synth_enable ##1 clk_en;
    endsequence

    // =====================================================================
    // Reset values
    a_fsr_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> full_scale_code == ccr_pkg::RST_FSR)
        else $error("full-scale code not at reset value");

    a_pwr_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> power_profile_code == ccr_pkg::RST_PWR)
        else $error("power profile not at reset value");

    a_timestamp_input_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> !timestamp_input_enable && timestamp_input_q == ccr_pkg::RST_TIMESTAMP_INPUT)
        else $error("timestamp control not at reset value");

    a_refo_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> refo_q == ccr_pkg::RST_REFO)
        else $error("reference output control not at reset value");

    a_div_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> div_q == ccr_pkg::RST_DIV1)
        else $error("divider register not at reset value");

    a_ratio_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> post_div_ratio == 3'h1 && first_div_ratio == 3'h5)
        else $error("divider ratios not at reset value");

    a_rdata_reset: assert property (@(posedge clk)
        $rose(reset_n) |-> rdata == 8'h00)
        else $error("read data not cleared by reset");

    // =====================================================================
    // Register writes and reads
    a_fsr_lo_write: assert property (@(posedge clk) disable iff (!reset_n)
        s_fsr_lo_write |=> full_scale_code[7:0] == $past(wdata))
        else $error("full-scale low byte write lost");

    a_fsr_hi_write: assert property (@(posedge clk) disable iff (!reset_n)
        s_fsr_hi_write |=> full_scale_code[15:8] == $past(wdata))
        else $error("full-scale high byte write lost");

    a_fs_floor_low: assert property (@(posedge clk) disable iff (!reset_n)
        s_fsr_hi_write ##0 (wdata < ccr_pkg::FSR_MIN_REC[15:8]) |=> fs_below_min)
        else $error("code under floor not flagged");

    a_fs_floor_high: assert property (@(posedge clk) disable iff (!reset_n)
        s_fsr_hi_write ##0 (wdata >= ccr_pkg::FSR_MIN_REC[15:8]) |=> !fs_below_min)
        else $error("code above floor flagged");

    a_pwr_write: assert property (@(posedge clk) disable iff (!reset_n)
        s_pwr_write |=> power_profile_code == $past(wdata))
        else $error("power profile write lost");

    a_pwr_low: assert property (@(posedge clk) disable iff (!reset_n)
        s_pwr_write ##0 (wdata == ccr_pkg::PWR_LOW) |=> power_low_mode && !power_reserved)
        else $error("low power code misdecoded");

    a_pwr_high: assert property (@(posedge clk) disable iff (!reset_n)
        s_pwr_write ##0 (wdata == ccr_pkg::PWR_HIGH) |=> !power_low_mode && !power_reserved)
        else $error("high performance code misdecoded");

    a_pwr_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
        s_pwr_write ##0 (wdata != ccr_pkg::PWR_LOW && wdata != ccr_pkg::PWR_HIGH)
        |=> power_reserved)
        else $error("reserved power code not flagged");

    a_timestamp_input_on: assert property (@(posedge clk) disable iff (!reset_n)
        s_timestamp_input_write ##0 wdata[ccr_pkg::BIT_TIMESTAMP_INPUT_EN] |=> timestamp_input_enable)
        else $error("timestamp input not enabled");

    a_div_write: assert property (@(posedge clk) disable iff (!reset_n)
        s_div_write |=> div_q == $past(wdata))
        else $error("divider write lost");

    a_pos_ro: assert property (@(posedge clk) disable iff (!reset_n)
        s_pos_poke |=> $stable(pos_q))
        else $error("status word moved on a write");

    a_fsr_read: assert property (@(posedge clk) disable iff (!reset_n)
        s_read_quiet ##0 (addr == ccr_pkg::OFS_FSR_HI) |=> rdata == full_scale_code[15:8])
        else $error("full-scale high byte read wrong");

    a_rdata_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !(clk_en && rd_en) |=> $stable(rdata))
        else $error("read data moved without a read");

    // =====================================================================
    // Clock enable and reference output gate
    a_frozen: assert property (@(posedge clk) disable iff (!reset_n)
        !clk_en |=> $stable(full_scale_code) && $stable(power_profile_code) &&
                    $stable(timestamp_input_q) && $stable(refo_q) && $stable(div_q))
        else $error("state moved with clock enable low");

    a_refo_gate: assert property (@(posedge clk) disable iff (!reset_n)
        s_refo_write ##0 !wdata[ccr_pkg::BIT_REFO_EN] |=> !ref_clock_output)
        else $error("reference output on with enable bit clear");

    a_refo_sync_low: assert property (@(posedge clk) disable iff (!reset_n)
        s_synth_low_held |=> !ref_clock_output)
        else $error("reference output on with synthesizer off");

    a_refo_sync_high: assert property (@(posedge clk) disable iff (!reset_n)
        s_synth_high_held ##0 (refo_q[ccr_pkg::BIT_REFO_EN] && !wr_en) |=> ref_clock_output)
        else $error("reference output off with both enables set");

    // =====================================================================
    // Divider decode
    a_post_map: assert property (@(posedge clk) disable iff (!reset_n)
        div_q[3:2] == 2'h2 |-> post_div_ratio == 3'h4)
        else $error("post divider code two misdecoded");

    a_first_map: assert property (@(posedge clk) disable iff (!reset_n)
        div_q[1:0] == 2'h2 |-> first_div_ratio == 3'h3)
        else $error("first divider code two misdecoded");

    a_post_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
        div_q[3:2] == 2'h3 |-> div_code_reserved && post_div_ratio == 3'h0)
        else $error("reserved post divider code not flagged");

    a_first_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
        div_q[1:0] == 2'h3 |-> div_code_reserved && first_div_ratio == 3'h0)
        else $error("reserved first divider code not flagged");

    a_div_legal: assert property (@(posedge clk) disable iff (!reset_n)
        div_q[3:2] != 2'h3 && div_q[1:0] != 2'h3 |-> !div_code_reserved)
        else $error("legal divider codes flagged reserved");
endmodule : ccr_regs

// >>> testbench/converter_config_register_slice_tb.sv
// Self-checking bench for the converter configuration register slice.
// Assumes ccr_pkg and ccr_regs are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
module converter_config_register_slice_tb;
    logic        clk, reset_n, clk_en, wr_en, rd_en, synth_enable;
    logic [7:0]  addr, wdata, rdata, power_profile_code;
    logic [23:0] sync_edge_position_in;
    logic [15:0] full_scale_code;
    logic        fs_below_min, power_low_mode, power_reserved;
    logic        timestamp_input_enable, ref_clock_output, div_code_reserved;
    logic [2:0]  post_div_ratio, first_div_ratio;
    int          n_mismatch, n_compared, i;
    logic [2:0]  post_tbl [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [2:0]  first_tbl[4] = '{3'h5, 3'h4, 3'h3, 3'h0};
    logic [7:0]  pw_tbl   [3] = '{8'h46, 8'h47, 8'h4b};

    ccr_regs i_dut (.clk, .reset_n, .clk_en, .wr_en, .rd_en, .addr, .wdata, .rdata,
        .sync_edge_position_in, .synth_enable, .full_scale_code, .fs_below_min,
        .power_profile_code, .power_low_mode, .power_reserved, .timestamp_input_enable,
        .ref_clock_output, .post_div_ratio, .first_div_ratio, .div_code_reserved);

    // =====================================================================
    // Access tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd
    task automatic print_verdict;
        $display("Counts: compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    // =====================================================================
    // Clock, watchdog and test sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole sequence is about a hundred cycles; four thousand is ample margin
    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        {reset_n, wr_en, rd_en, addr, wdata, synth_enable} = '0;
        clk_en = 1'b1;
        sync_edge_position_in = 24'h5a3c17;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd(ccr_pkg::OFS_FSR_LO, 8'h00);
        rd(ccr_pkg::OFS_FSR_HI, 8'ha0);
        rd(ccr_pkg::OFS_PWR, 8'h4b);
        rd(ccr_pkg::OFS_TIMESTAMP_INPUT, 8'h00);
        rd(ccr_pkg::OFS_REFO, 8'h01);
        rd(ccr_pkg::OFS_DIV1, 8'h00);
        chk(ref_clock_output, 1'b0);
        for (i = 0; i < 3; i++) wr(ccr_pkg::OFS_POS_LO + 8'(i), 8'hff);
        rd(ccr_pkg::OFS_POS_LO, 8'h17);
        rd(ccr_pkg::OFS_POS_MID, 8'h3c);
        rd(ccr_pkg::OFS_POS_HI, 8'h5a);
        sync_edge_position_in <= 24'ha5c3e8;
        rd(ccr_pkg::OFS_POS_HI, 8'h5a);
        // Status word waits for two equal samples after the synchroniser
        repeat (2) @(posedge clk);
        rd(ccr_pkg::OFS_POS_HI, 8'ha5);
        wr(ccr_pkg::OFS_FSR_LO, 8'hff);
        wr(ccr_pkg::OFS_FSR_HI, 8'hff);
        chk(full_scale_code, 16'hffff);
        chk(fs_below_min, 1'b0);
        wr(ccr_pkg::OFS_FSR_HI, 8'h1f);
        chk(fs_below_min, 1'b1);
        rd(ccr_pkg::OFS_FSR_HI, 8'h1f);
        for (i = 0; i < 3; i++) begin
            // Companion profile registers, enables and calibration sit outside this slice
            wr(ccr_pkg::OFS_PWR, pw_tbl[i]);
            chk(power_profile_code, pw_tbl[i]);
            chk(power_low_mode, pw_tbl[i] == 8'h46);
            chk(power_reserved, pw_tbl[i] == 8'h47);
        end
        // Frozen clock enable must swallow the write
        @(posedge clk);
        clk_en <= 1'b0;
        wr(ccr_pkg::OFS_TIMESTAMP_INPUT, 8'h01);
        chk(timestamp_input_enable, 1'b0);
        clk_en <= 1'b1;
        wr(ccr_pkg::OFS_TIMESTAMP_INPUT, 8'h01);
        chk(timestamp_input_enable, 1'b1);
        synth_enable <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(ref_clock_output, 1'b1);
        wr(ccr_pkg::OFS_REFO, 8'h00);
        chk(ref_clock_output, 1'b0);
        wr(ccr_pkg::OFS_REFO, 8'h01);
        synth_enable <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(ref_clock_output, 1'b0);
        // Reserved high nibble stays zero on every divider write
        for (i = 0; i < 16; i++) begin
            wr(ccr_pkg::OFS_DIV1, 8'(i));
            chk(post_div_ratio, post_tbl[i / 4]);
            chk(first_div_ratio, first_tbl[i % 4]);
            chk(div_code_reserved, (i / 4 == 3) || (i % 4 == 3));
        end
        wr(8'h40, 8'h5a);
        rd(8'h40, 8'h00);
        print_verdict();
    end
endmodule : converter_config_register_slice_tb
